// [tb/osc_clock_ctrl_test.sv]
// Self-checking testbench for the oscillator switch and clock divider block
`timescale 1ns/1ps
`default_nettype none
`include "osc_clock_defs.svh"
module osc_clock_ctrl_test;
  import osc_clock_pkg::*;
  // ****************
  // Signals and model
  // ****************
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  pins_t       pins;
  logic        irq;
  logic        wdt;
  logic [4:0]  osc_en;
  logic [2:0]  sys_src;
  logic        trap;
  logic [2:0]  cpu_div;
  pll_cfg_t    pll_cfg;
  int          err_total;
  int          cmp_count;
  int          cyc;
  int          n;
  logic [31:0] seed;
  logic [31:0] rdat;
  logic [15:0] div_m;
  logic [15:0] v;
  logic [8:0]  fb_m;
  logic [5:0]  tun_m;

  osc_clock_ctrl osc_clock_ctrl_i (
    .REF_CLK    (clk),
    .RST        (rst),
    .HSEL       (hsel),
    .HADDR      (haddr),
    .HTRANS     (htrans),
    .HWRITE     (hwrite),
    .HSIZE      (3'h2),
    .HWDATA     (hwdata),
    .HREADY     (hreadyout),
    .HREADYOUT  (hreadyout),
    .HRESP      (hresp),
    .HRDATA     (hrdata),
    .ASYNC_IN   (pins),
    .INTERRUPT  (irq),
    .WDT_ENABLE (wdt),
    .OSC_ENABLE (osc_en),
    .SYS_SOURCE (sys_src),
    .FAIL_TRAP  (trap),
    .CPU_DIV_LOG2 (cpu_div),
    .PLL_CFG    (pll_cfg)
  );

  always #2.5 clk = ~clk;

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask

  // No wait limit of its own; only the hang guard ends a stuck wait
  task automatic rdy();
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask

  // One single transfer; read data lands in rdat
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rdat = hrdata;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask

  // Unlocked write to oscillator control
  task automatic ow(input logic [31:0] d);
    bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY1);
    bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY2);
    bus(1'b1, `OFS_OSC_CTRL, d);
  endtask

  task automatic tog(input int k);
    repeat (k) begin
      wt(4);
      pins.new_clk_toggle <= ~pins.new_clk_toggle;
    end
  endtask

  task automatic trapcnt();
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 if (trap === 1'b1) n++;
    end
  endtask

  task automatic cfgchk();
    chk(32'({div_m[4:0], fb_m, div_m[7:6],
        (div_m[10:8] == 3'h7) ? 4'h8 : {1'b0, div_m[10:8]}, tun_m}), 32'(pll_cfg));
    chk(32'(cpu_div), div_m[11] ? 32'(div_m[14:12]) : 32'h0);
  endtask

  task automatic tend(input string s);
    $display("test %s done, mismatches so far %0d", s, err_total);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    irq = 1'b0;
    wdt = 1'b0;
    pins = '0;
    pins.lock_permit_fuse = 1'b1;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    seed = 32'hd1e0;
    div_m = 16'h3040;
    fb_m = 9'h030;
    tun_m = 6'h00;
    wt(10);
    rst <= 1'b0;
    wt(6);
    rchk(`OFS_CLK_DIV, 32'hffff_ffff, 32'h3040);
    rchk(`OFS_PLL_FB, 32'hffff_ffff, 32'h30);
    rchk(`OFS_RC_TUNE, 32'hffff_ffff, 32'h0);
    rchk(`OFS_OSC_CTRL, 32'h7709, 32'h0);
    cfgchk();
    tend("reset");
    // Fixed corner codes first, then pseudo-random words
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'h07c0 : (i == 1) ? 16'h0780 : seed[15:0];
      bus(1'b1, `OFS_CLK_DIV, {seed[31:16], v});
      bus(1'b1, `OFS_PLL_FB, seed);
      bus(1'b1, `OFS_RC_TUNE, seed);
      v = v & 16'hffdf;
      if (v[7:6] == `PLL_POST_RSVD) v[7:6] = div_m[7:6];
      div_m = v;
      fb_m = seed[8:0];
      tun_m = seed[5:0];
      rchk(`OFS_CLK_DIV, 32'hffff_ffff, {16'h0, div_m});
      rchk(`OFS_PLL_FB, 32'hffff_ffff, {23'h0, fb_m});
      rchk(`OFS_RC_TUNE, 32'hffff_ffff, {26'h0, tun_m});
      cfgchk();
    end
    tend("divisors");
    // Interrupt recovery from doze, with and without recovery enabled
    for (int i = 0; i < 2; i++) begin
      div_m = (i == 0) ? 16'hd840 : 16'h5840;
      bus(1'b1, `OFS_CLK_DIV, {16'h0, div_m});
      cfgchk();
      irq <= 1'b1;
      wt(1);
      irq <= 1'b0;
      wt(2);
      if (i == 0) div_m[11] = 1'b0;
      rchk(`OFS_CLK_DIV, 32'hffff_ffff, {16'h0, div_m});
      cfgchk();
    end
    tend("doze");
    // Crystal switch: waits for start-up timer, then ten new-clock cycles
    ow(32'h0200);
    ow(32'h0201);
    tog(10);
    wt(8);
    chk(32'(sys_src), 32'h0);
    rchk(`OFS_OSC_CTRL, 32'h7701, 32'h0201);
    pins.osc_startup_timer_done <= 1'b1;
    wt(4);
    tog(9);
    wt(8);
    chk(32'(sys_src), 32'h0);
    tog(1);
    wt(8);
    chk(32'(sys_src), 32'h2);
    rchk(`OFS_OSC_CTRL, 32'h7701, 32'h2200);
    chk(32'(osc_en), 32'h0a);
    // PLL switch waits for lock
    ow(32'h0300);
    ow(32'h0301);
    tog(12);
    wt(8);
    chk(32'(sys_src), 32'h2);
    rchk(`OFS_OSC_CTRL, 32'h0020, 32'h0);
    pins.pll_locked <= 1'b1;
    wt(4);
    tog(10);
    wt(8);
    chk(32'(sys_src), 32'h3);
    rchk(`OFS_OSC_CTRL, 32'h7721, 32'h3320);
    ow(32'h0301);
    wt(4);
    rchk(`OFS_OSC_CTRL, 32'h7701, 32'h3300);
    bus(1'b1, `OFS_OSC_CTRL, 32'h0401);
    wt(4);
    rchk(`OFS_OSC_CTRL, 32'h7701, 32'h3300);
    chk(32'(sys_src), 32'h3);
    tend("switch");
    // Failure while on primary with PLL falls back to RC with PLL
    pins.clk_fail <= 1'b1;
    trapcnt();
    chk(32'(n), 32'h1);
    chk(32'(sys_src), 32'h1);
    rchk(`OFS_OSC_CTRL, 32'h7008, 32'h1008);
    pins.clk_fail <= 1'b0;
    ow(32'h0000);
    ow(32'h0001);
    wt(4);
    rchk(`OFS_OSC_CTRL, 32'h0028, 32'h0020);
    tog(10);
    wt(8);
    chk(32'(sys_src), 32'h0);
    ow(32'h0008);
    rchk(`OFS_OSC_CTRL, 32'h0008, 32'h0);
    tend("failsafe");
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rchk(8'h20, 32'hffff_ffff, 32'h0);
    chk(32'(hresp), 32'h0);
    // Lock cannot be undone, so it comes last
    ow(32'h0080);
    rchk(`OFS_OSC_CTRL, 32'h0080, 32'h0080);
    bus(1'b1, `OFS_PLL_FB, 32'h1ff);
    rchk(`OFS_PLL_FB, 32'hffff_ffff, {23'h0, fb_m});
    ow(32'h0281);
    wt(4);
    rchk(`OFS_OSC_CTRL, 32'h0701, 32'h0);
    pins.switch_enable_fuse <= 1'b1;
    pins.initial_source_fuses <= 3'h4;
    wt(8);
    chk(32'(sys_src), 32'h4);
    chk(32'(osc_en), 32'h04);
    wdt <= 1'b1;
    wt(2);
    chk(32'(osc_en), 32'h0c);
    rchk(`OFS_OSC_CTRL, 32'h7001, 32'h4000);
    pins.clk_fail <= 1'b1;
    trapcnt();
    chk(32'(n), 32'h0);
    tend("lock and disable");
    end_of_test();
  end
endmodule
`default_nettype wire

// [verilog/osc_clock_ctrl.sv]
// Oscillator switch, clock divider and fail-safe fallback with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "osc_clock_defs.svh"
module osc_clock_ctrl (
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic                         HREADYOUT,
  output logic                         HRESP,
  output logic [31:0]                  HRDATA,
  input  wire osc_clock_pkg::pins_t    ASYNC_IN,
  input  wire logic                    INTERRUPT,
  input  wire logic                    WDT_ENABLE,
  output logic [4:0]                   OSC_ENABLE,
  output logic [2:0]                   SYS_SOURCE,
  output logic                         FAIL_TRAP,
  output logic [2:0]                   CPU_DIV_LOG2,
  output osc_clock_pkg::pll_cfg_t      PLL_CFG
);
  import osc_clock_pkg::*;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pins_t      s1;
    pins_t      s2;
    logic       tick_prev;
    logic       fail_prev;
    logic [1:0] load_cnt;
    logic       ap_valid;
    logic       ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [1:0] unlock;
    logic [2:0] current_source_sel;
    logic [2:0] new_source_sel;
    logic [2:0] target;
    logic       clock_config_lock;
    logic       pll_lock;
    logic       cf;
    logic       sec_en;
    logic       switch_request;
    logic       recover_on_interrupt;
    logic [2:0] doze;
    logic       doze_enable;
    logic [2:0] rc_div;
    logic [1:0] pll_post;
    logic [4:0] pll_pre;
    logic [8:0] pll_mult;
    logic [5:0] rc_trim;
    sw_state_t  fsm;
    logic [3:0] tick_cnt;
    logic       trap;
    logic [4:0] osc_en;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == `SRC_FRC_PLL) || (src == `SRC_PRI_PLL);
  endfunction

  // Oscillators a source needs: {pll, low_power_internal_rc, secondary, primary, fast rc}
  function automatic logic [4:0] osc_of(input logic [2:0] src);
    logic [4:0] m;
    m = 5'h00;
    case (src)
      `SRC_FRC_PLL: m = 5'h11;
      `SRC_PRI:     m = 5'h02;
      `SRC_PRI_PLL: m = 5'h12;
      `SRC_SEC:     m = 5'h04;
      `SRC_LOW_POWER_INTERNAL_RC:    m = 5'h08;
      default:      m = 5'h01;
    endcase
    osc_of = m;
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `OFS_OSC_CTRL: d = {17'h00000, s.current_source_sel, 1'b0, s.new_source_sel, s.clock_config_lock, 1'b0, s.pll_lock,
                          1'b0, s.cf, 1'b0, s.sec_en, s.switch_request};
      `OFS_CLK_DIV:  d = {16'h0000, s.recover_on_interrupt, s.doze, s.doze_enable, s.rc_div, s.pll_post, 1'b0,
                          s.pll_pre};
      `OFS_PLL_FB:   d = {23'h000000, s.pll_mult};
      `OFS_RC_TUNE:  d = {26'h0000000, s.rc_trim};
      `OFS_UNLOCK:   d = {30'h00000000, s.unlock};
      default:       d = 32'h0000_0000;
    endcase
    read_mux = d;
  endfunction

  logic sw_en;
  logic cfg_locked;
  logic tick;
  logic fail_edge;
  logic target_ready;
  logic ap_take;
  logic wr_now;

  always_comb begin
    sw_en      = ~state_reg.s2.switch_enable_fuse;
    cfg_locked = state_reg.clock_config_lock & state_reg.s2.lock_permit_fuse;
    tick       = state_reg.s2.new_clk_toggle ^ state_reg.tick_prev;
    fail_edge  = state_reg.s2.clk_fail & ~state_reg.fail_prev;
    // Crystal waits on start-up timer, PLL sources on lock
    if (uses_pll(state_reg.target)) begin
      target_ready = state_reg.s2.pll_locked;
    end else if (state_reg.target == `SRC_PRI) begin
      target_ready = state_reg.s2.osc_startup_timer_done;
    end else begin
      target_ready = 1'b1;
    end
    ap_take = HSEL & HTRANS[1] & HREADY;
    wr_now  = state_reg.ap_valid & state_reg.ap_write;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.s1        = ASYNC_IN;
    state_next.s2        = state_reg.s1;
    state_next.tick_prev = state_reg.s2.new_clk_toggle;
    state_next.fail_prev = state_reg.s2.clk_fail;
    state_next.trap      = 1'b0;

    // Fuses are only trusted once through the synchroniser
    if (state_reg.load_cnt != 2'h3) begin
      state_next.load_cnt = state_reg.load_cnt + 2'h1;
      if (state_reg.load_cnt == 2'h2) begin
        state_next.current_source_sel = state_reg.s2.initial_source_fuses;
        state_next.new_source_sel = state_reg.s2.initial_source_fuses;
      end
    end

    // Bus address phase; read data captured here, so zero wait states
    state_next.ap_valid = ap_take;
    state_next.ap_write = ap_take & HWRITE;
    state_next.ap_addr  = HADDR[7:0];
    if (ap_take && !HWRITE) begin
      state_next.rdata = read_mux(state_reg, HADDR[7:0]);
    end

    // Bus data phase
    if (wr_now) begin
      if (state_reg.ap_addr != `OFS_UNLOCK) begin
        state_next.unlock = 2'h0;
      end
      case (state_reg.ap_addr)
        `OFS_UNLOCK: begin
          if (HWDATA == `UNLOCK_KEY1) begin
            state_next.unlock = 2'h1;
          end else if (state_reg.unlock == 2'h1 && HWDATA == `UNLOCK_KEY2) begin
            state_next.unlock = 2'h2;
          end else begin
            state_next.unlock = 2'h0;
          end
        end
        `OFS_OSC_CTRL: begin
          if (state_reg.unlock == 2'h2) begin
            state_next.sec_en = HWDATA[1];
            state_next.clock_config_lock = state_reg.clock_config_lock | HWDATA[7];
            if (!HWDATA[3]) begin
              state_next.cf = 1'b0;
            end
            if (sw_en && !cfg_locked) begin
              state_next.new_source_sel = HWDATA[10:8];
              if (HWDATA[0] && state_reg.fsm == SW_IDLE) begin
                state_next.switch_request = 1'b1;
              end
            end
          end
        end
        `OFS_CLK_DIV: begin
          state_next.recover_on_interrupt    = HWDATA[15];
          state_next.doze   = HWDATA[14:12];
          state_next.doze_enable  = HWDATA[11];
          state_next.rc_div = HWDATA[10:8];
          if (!cfg_locked) begin
            state_next.pll_pre = HWDATA[4:0];
            // Reserved divider code is dropped, old setting kept
            if (HWDATA[7:6] != `PLL_POST_RSVD) begin
              state_next.pll_post = HWDATA[7:6];
            end
          end
        end
        `OFS_PLL_FB: begin
          if (!cfg_locked) begin
            state_next.pll_mult = HWDATA[8:0];
          end
        end
        `OFS_RC_TUNE: begin
          state_next.rc_trim = HWDATA[5:0];
        end
        default: begin
        end
      endcase
    end

    // Interrupt wins over a same-cycle software write of doze
    if (state_reg.recover_on_interrupt && INTERRUPT) begin
      state_next.doze_enable = 1'b0;
    end

    // PLL lock status follows the lock pin while a PLL is in use
    state_next.pll_lock = state_reg.s2.pll_locked &
                          (uses_pll(state_reg.current_source_sel) || uses_pll(state_reg.target));

    // ************************************************************
    // Switch sequence
    // ************************************************************
    case (state_reg.fsm)
      SW_IDLE: begin
        if (state_reg.switch_request) begin
          if (state_reg.new_source_sel == state_reg.current_source_sel) begin
            state_next.switch_request = 1'b0;
          end else begin
            state_next.pll_lock = 1'b0;
            state_next.cf       = 1'b0;
            state_next.target   = state_reg.new_source_sel;
            state_next.fsm      = SW_START;
          end
        end
      end
      SW_START: begin
        if (target_ready) begin
          state_next.tick_cnt = 4'h0;
          state_next.fsm      = SW_COUNT;
        end
      end
      SW_COUNT: begin
        if (tick) begin
          state_next.tick_cnt = state_reg.tick_cnt + 4'h1;
          if (state_reg.tick_cnt == `SWITCH_TICKS - 4'h1) begin
            state_next.fsm = SW_DONE;
          end
        end
      end
      SW_DONE: begin
        state_next.current_source_sel  = state_reg.target;
        state_next.switch_request = 1'b0;
        state_next.fsm   = SW_IDLE;
      end
      default: begin
        state_next.fsm = SW_IDLE;
      end
    endcase

    // Monitor fallback overrides any switch in progress
    if (sw_en && fail_edge) begin
      state_next.cf    = 1'b1;
      state_next.trap  = 1'b1;
      state_next.switch_request = 1'b0;
      state_next.fsm   = SW_IDLE;
      state_next.target = uses_pll(state_reg.current_source_sel) ? `SRC_FRC_PLL : `SRC_FRC;
      state_next.current_source_sel   = uses_pll(state_reg.current_source_sel) ? `SRC_FRC_PLL : `SRC_FRC;
    end

    if (!sw_en) begin
      state_next.switch_request = 1'b0;
      state_next.fsm   = SW_IDLE;
      if (state_reg.load_cnt == 2'h3) begin
        state_next.current_source_sel = state_reg.s2.initial_source_fuses;
      end
    end

    // Old source drops once no longer current or targeted
    state_next.osc_en = osc_of(state_reg.current_source_sel) |
                        ((state_reg.fsm != SW_IDLE) ? osc_of(state_reg.target) : 5'h00) |
                        ((WDT_ENABLE || sw_en) ? 5'h08 : 5'h00) |
                        (state_reg.sec_en ? 5'h04 : 5'h00);
  end

  // ************************************************************
  // Registers; RST is the power-on reset only
  // ************************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg          <= '0;
      state_reg.fsm      <= SW_IDLE;
      state_reg.doze     <= `RST_DOZE;
      state_reg.rc_div   <= `RST_RC_DIV;
      state_reg.pll_post <= `RST_PLL_POST;
      state_reg.pll_pre  <= `RST_PLL_PRE;
      state_reg.pll_mult <= `RST_PLL_MULT;
      state_reg.rc_trim  <= `RST_RC_TRIM;
      state_reg.osc_en   <= 5'h01;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    HREADYOUT    = 1'b1;
    HRESP        = 1'b0;
    HRDATA       = state_reg.rdata;
    OSC_ENABLE   = state_reg.osc_en;
    SYS_SOURCE   = state_reg.current_source_sel;
    FAIL_TRAP    = state_reg.trap;
    CPU_DIV_LOG2 = state_reg.doze_enable ? state_reg.doze : 3'h0;
    PLL_CFG.pll_input_prescaler = state_reg.pll_pre;
    PLL_CFG.pll_multiplier      = state_reg.pll_mult;
    PLL_CFG.pll_output_divider  = state_reg.pll_post;
    // Code 7 jumps to divide by 256
    PLL_CFG.rc_div_log2 = (state_reg.rc_div == 3'h7) ? 4'h8 : {1'b0, state_reg.rc_div};
    PLL_CFG.rc_trim     = state_reg.rc_trim;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_switch_abort: assert property (
    (state_reg.fsm == SW_IDLE && state_reg.switch_request && state_reg.new_source_sel == state_reg.current_source_sel)
    |=> !state_reg.switch_request && state_reg.fsm == SW_IDLE)
    else $error("redundant switch not abandoned");

  a_start_clears: assert property (
    (state_reg.fsm == SW_IDLE && state_reg.switch_request && state_reg.new_source_sel != state_reg.current_source_sel
     && sw_en && !fail_edge)
    |=> state_reg.fsm == SW_START && !state_reg.cf && !state_reg.pll_lock)
    else $error("switch start did not clear status");

  a_ready_wait: assert property (
    (state_reg.fsm == SW_START && !target_ready && sw_en && !fail_edge)
    |=> state_reg.fsm == SW_START)
    else $error("switch left start before source ready");

  a_count_ten: assert property (
    (state_reg.fsm == SW_COUNT && !(tick && state_reg.tick_cnt == 4'h9) && sw_en && !fail_edge)
    |=> state_reg.fsm == SW_COUNT)
    else $error("switch finished before ten new-clock cycles");

  a_switch_done: assert property (
    (state_reg.fsm == SW_DONE && sw_en && !fail_edge)
    |=> SYS_SOURCE == $past(state_reg.target) && !state_reg.switch_request)
    else $error("completion did not update source");

  a_disabled_hold: assert property (
    !sw_en |=> !state_reg.switch_request && state_reg.fsm == SW_IDLE)
    else $error("request not held at zero while disabled");

  a_doze_recover: assert property (
    (state_reg.recover_on_interrupt && INTERRUPT) |=> !state_reg.doze_enable && CPU_DIV_LOG2 == 3'h0)
    else $error("interrupt did not clear doze");

  a_ratio_one: assert property (
    !state_reg.doze_enable |-> CPU_DIV_LOG2 == 3'h0)
    else $error("ratio not 1:1 with doze off");

  a_fail_move: assert property (
    (sw_en && fail_edge) |=> FAIL_TRAP && state_reg.cf
      && SYS_SOURCE == (uses_pll($past(state_reg.current_source_sel)) ? `SRC_FRC_PLL : `SRC_FRC))
    else $error("clock failure fallback wrong");

  a_post_legal: assert property (
    state_reg.pll_post != `PLL_POST_RSVD)
    else $error("reserved pll output divider code");

  a_lock_block: assert property (
    (cfg_locked && wr_now && state_reg.ap_addr == `OFS_PLL_FB) |=> $stable(state_reg.pll_mult))
    else $error("locked pll multiplier changed");
endmodule
`default_nettype wire

// [verilog/osc_clock_defs.svh]
// Constants for the oscillator switch and clock divider block
`ifndef OSC_CLOCK_DEFS_SVH
`define OSC_CLOCK_DEFS_SVH
`define OFS_OSC_CTRL    8'h00
`define OFS_CLK_DIV     8'h04
`define OFS_PLL_FB      8'h08
`define OFS_RC_TUNE     8'h0c
`define OFS_UNLOCK      8'h10
`define UNLOCK_KEY1     32'h0000_0046
`define UNLOCK_KEY2     32'h0000_0057
`define RST_DOZE        3'h3
`define RST_PLL_POST    2'h1
`define RST_PLL_PRE     5'h00
`define RST_PLL_MULT    9'h030
`define RST_RC_DIV      3'h0
`define RST_RC_TRIM     6'h00
`define SWITCH_TICKS    4'ha
`define SRC_FRC         3'h0
`define SRC_FRC_PLL     3'h1
`define SRC_PRI         3'h2
`define SRC_PRI_PLL     3'h3
`define SRC_SEC         3'h4
`define SRC_LOW_POWER_INTERNAL_RC        3'h5
`define PLL_POST_RSVD   2'h2
`endif

// [verilog/osc_clock_pkg.sv]
// Types for the oscillator switch and clock divider block
package osc_clock_pkg;
  // Pins from outside the clock domain, synchronised as one group
  typedef struct packed {
    logic       clk_fail;
    logic       pll_locked;
    logic       osc_startup_timer_done;
    logic       new_clk_toggle;
    logic       switch_enable_fuse;
    logic       lock_permit_fuse;
    logic [2:0] initial_source_fuses;
  } pins_t;

  typedef struct packed {
    logic [4:0] pll_input_prescaler;
    logic [8:0] pll_multiplier;
    logic [1:0] pll_output_divider;
    logic [3:0] rc_div_log2;
    logic [5:0] rc_trim;
  } pll_cfg_t;

  typedef enum logic [3:0] {
    SW_IDLE  = 4'b0001,
    SW_START = 4'b0010,
    SW_COUNT = 4'b0100,
    SW_DONE  = 4'b1000
  } sw_state_t;
endpackage
